// ### fda_pkg.sv
// constants and types for the fifo diagnostic and abort recovery block
// Contract
// - lane-select top bit 0 disables test access; 100..111 pick lanes 0..3.
// - test data write pushes byte into selected lane with parity-write bit 3.
// - test data read pops selected lane; parity appears in test status bit 3.
// - dma fifo is four lanes, each eight entries of nine bits.
// - with link fifo write enable set, output latch writes load the link fifo.
// - readback read pops link fifo and latches its parity in status bit 4.
// - generation off takes host parity pins; on gives odd or even parity.
// - abort stops instruction execution and resets nothing else.
// - reading dma status clears a pending abort interrupt.
// - interrupt status bit 7 requests abort; left set, it re-raises the interrupt.
// - abort waits for the host burst and, on receive, an empty dma fifo.
// - after abort or disconnect the byte counter holds bytes still to move.
// - (pointer low six minus counter low six) and 3F gives dma fifo bytes.
// - link status 1 bit 5 shows the output latch holds an unsent byte.
// - link status 1 bit 6 shows the holding register holds an unsent byte.
// - writing 1 to pointer register bit 6 clears both fifos.
// - writing the instruction pointer starts fetching a new sequence.
// - interrupt status bit 3 shows the device is connected on the link.
// - connected flag reflects selection during abort once the interrupt rises.
// - after unexpected disconnect the pointer is executing address plus 8.
package fda_pkg;
  localparam logic [3:0] DIAG_CTRL_ADDR     = 4'h0;
  localparam logic [3:0] DMA_TEST_DATA_ADDR = 4'h1;
  localparam logic [3:0] PARITY_WRITE_ADDR  = 4'h2;
  localparam logic [3:0] TEST_STATUS_ADDR   = 4'h3;
  localparam logic [3:0] LINK_READBACK_ADDR = 4'h4;
  localparam logic [3:0] OUT_LATCH_ADDR     = 4'h5;
  localparam logic [3:0] LINK_CTRL0_ADDR    = 4'h6;
  localparam logic [3:0] LINK_CTRL1_ADDR    = 4'h7;
  localparam logic [3:0] DMA_STATUS_ADDR    = 4'h8;
  localparam logic [3:0] INT_STATUS_ADDR    = 4'h9;
  localparam logic [3:0] BYTE_COUNT_ADDR    = 4'hA;
  localparam logic [3:0] IP_LO_ADDR         = 4'hB;
  localparam logic [3:0] IP_HI_ADDR         = 4'hC;
  localparam logic [3:0] LINK_STATUS1_ADDR  = 4'hD;
  localparam logic [3:0] DMA_PTR_ADDR       = 4'hE;

  localparam int LANE_EN_BIT     = 2;
  localparam int LINK_FIFO_WE_BIT = 3;
  localparam int PAR_WRITE_BIT   = 3;
  localparam int DMA_PAR_BIT     = 3;
  localparam int LINK_PAR_BIT    = 4;
  localparam int PAR_GEN_BIT     = 2;
  localparam int EVEN_PAR_BIT    = 2;
  localparam int ABORT_FLAG_BIT  = 4;
  localparam int SW_ABORT_BIT    = 7;
  localparam int CONNECTED_BIT   = 3;
  localparam int LATCH_FULL_BIT  = 5;
  localparam int HOLD_FULL_BIT   = 6;
  localparam int FIFO_CLEAR_BIT  = 6;

  localparam int LANES           = 4;
  localparam int DEPTH           = 8;
  localparam logic [5:0]  PTR_MASK = 6'h3F;
  localparam logic [15:0] IP_STEP  = 16'h0008;
  localparam logic [7:0]  RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fda_bus_s;

  typedef struct packed {
    logic       par;
    logic [7:0] data;
  } fda_entry_s;
endpackage

// ### fda_diag_abort.sv
// fifo diagnostic access, abort sequencing and residual-count state
`timescale 1ns/1ns
`default_nettype none
module fda_diag_abort (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire fda_pkg::fda_bus_s bus,
  output logic [7:0]             rdData,
  input  wire logic [3:0]        hostParity,
  input  wire logic              abortPinN,
  input  wire logic              burstActive,
  input  wire logic              receiveMode,
  input  wire logic              dmaIn,
  input  wire logic              dmaOut,
  input  wire logic              instrFetch,
  input  wire logic              linkConnected,
  input  wire logic              linkDisconnect,
  input  wire logic              syncMode,
  input  wire logic              latchTake,
  input  wire logic              holdSent,
  output logic                   running,
  output logic                   startFetch,
  output logic [15:0]            instrPtr,
  output logic [7:0]             linkOutByte
);
  import fda_pkg::*;

  function automatic logic oddPar(input logic [7:0] d);
    oddPar = ~^d;
  endfunction

  logic [7:0]  diagCtrl_r;
  logic [7:0]  parWrite_r;
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic        dmaPar_r;
  logic        linkPar_r;
  logic        swAbort_r;
  logic        abortPend_r;
  logic        abortFlag_r;
  logic        running_r;
  logic        start_r;
  logic [15:0] ip_r;
  logic [7:0]  byteCnt_r;
  logic [5:0]  fifoPtr_r;
  logic        latchFull_r;
  logic        holdFull_r;
  logic [7:0]  latch_r;
  logic [7:0]  hold_r;
  logic [7:0]  rdData_r;
  fda_entry_s  lane_r [LANES][DEPTH];
  logic [2:0]  laneWp_r [LANES];
  logic [2:0]  laneRp_r [LANES];
  logic [3:0]  laneCnt_r [LANES];
  fda_entry_s  link_r [DEPTH];
  logic [2:0]  linkWp_r;
  logic [2:0]  linkRp_r;
  logic [3:0]  linkCnt_r;

  logic        wrHit [16];
  logic        rdHit [16];
  logic        laneOn;
  logic [1:0]  laneSel;
  logic        lanePush;
  logic        lanePop;
  logic        linkPush;
  logic        linkPop;
  logic        fifoClear;
  logic        linkParIn;
  logic        abortReq;
  logic        abortFire;
  logic        statusRead;
  fda_entry_s  laneHead;
  fda_entry_s  linkHead;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      wrHit[i] = bus.wr && (bus.addr == 4'(i));
      rdHit[i] = bus.rd && (bus.addr == 4'(i));
    end
  end

  assign laneOn    = diagCtrl_r[LANE_EN_BIT];
  assign laneSel   = diagCtrl_r[1:0];
  assign lanePush  = laneOn && wrHit[DMA_TEST_DATA_ADDR]
                     && (laneCnt_r[laneSel] != 4'(DEPTH));
  assign lanePop   = laneOn && rdHit[DMA_TEST_DATA_ADDR]
                     && (laneCnt_r[laneSel] != 4'h0);
  assign linkPush  = diagCtrl_r[LINK_FIFO_WE_BIT] && wrHit[OUT_LATCH_ADDR]
                     && (linkCnt_r != 4'(DEPTH));
  assign linkPop   = rdHit[LINK_READBACK_ADDR] && (linkCnt_r != 4'h0);
  assign fifoClear = wrHit[DMA_PTR_ADDR] && bus.wdata[FIFO_CLEAR_BIT];
  assign laneHead  = lane_r[laneSel][laneRp_r[laneSel]];
  assign linkHead  = link_r[linkRp_r];
  assign statusRead = rdHit[DMA_STATUS_ADDR];

  // pass-through uses the pin of the lane the byte arrives on, lane 0 here
  always_comb begin
    if (!ctrl0_r[PAR_GEN_BIT]) begin
      linkParIn = hostParity[0];
    end else if (ctrl1_r[EVEN_PAR_BIT]) begin
      linkParIn = ~oddPar(bus.wdata);
    end else begin
      linkParIn = oddPar(bus.wdata);
    end
  end

  // the shared pin only aborts while generation is off
  assign abortReq  = swAbort_r || (!abortPinN && !ctrl0_r[PAR_GEN_BIT]);
  assign abortFire = abortPend_r && !burstActive
                     && !(receiveMode && laneCnt_r[0] != 4'h0
                          && fifoPtr_r != byteCnt_r[5:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      diagCtrl_r <= RESET_BYTE;
      parWrite_r <= RESET_BYTE;
      ctrl0_r    <= RESET_BYTE;
      ctrl1_r    <= RESET_BYTE;
    end else begin
      if (wrHit[DIAG_CTRL_ADDR]) begin
        diagCtrl_r <= {4'h0, bus.wdata[3:0]};
      end
      if (wrHit[PARITY_WRITE_ADDR]) begin
        parWrite_r <= bus.wdata;
      end
      if (wrHit[LINK_CTRL0_ADDR]) begin
        ctrl0_r <= bus.wdata;
      end
      if (wrHit[LINK_CTRL1_ADDR]) begin
        ctrl1_r <= bus.wdata;
      end
    end
  end

  // dma fifo lanes: circular, so read order equals write order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int l = 0; l < LANES; l++) begin
        laneWp_r[l]  <= 3'h0;
        laneRp_r[l]  <= 3'h0;
        laneCnt_r[l] <= 4'h0;
      end
    end else if (fifoClear) begin
      for (int l = 0; l < LANES; l++) begin
        laneWp_r[l]  <= 3'h0;
        laneRp_r[l]  <= 3'h0;
        laneCnt_r[l] <= 4'h0;
      end
    end else begin
      if (lanePush) begin
        laneWp_r[laneSel] <= laneWp_r[laneSel] + 3'h1;
      end
      if (lanePop) begin
        laneRp_r[laneSel] <= laneRp_r[laneSel] + 3'h1;
      end
      if (lanePush && !lanePop) begin
        laneCnt_r[laneSel] <= laneCnt_r[laneSel] + 4'h1;
      end else if (lanePop && !lanePush) begin
        laneCnt_r[laneSel] <= laneCnt_r[laneSel] - 4'h1;
      end
    end
  end

  // storage has no reset; empty is known from the counts
  always_ff @(posedge clk) begin
    if (lanePush) begin
      lane_r[laneSel][laneWp_r[laneSel]] <= '{par: parWrite_r[PAR_WRITE_BIT],
                                             data: bus.wdata};
    end
    if (linkPush) begin
      link_r[linkWp_r] <= '{par: linkParIn, data: bus.wdata};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkWp_r  <= 3'h0;
      linkRp_r  <= 3'h0;
      linkCnt_r <= 4'h0;
    end else if (fifoClear) begin
      linkWp_r  <= 3'h0;
      linkRp_r  <= 3'h0;
      linkCnt_r <= 4'h0;
    end else begin
      if (linkPush) begin
        linkWp_r <= linkWp_r + 3'h1;
      end
      if (linkPop) begin
        linkRp_r <= linkRp_r + 3'h1;
      end
      if (linkPush && !linkPop) begin
        linkCnt_r <= linkCnt_r + 4'h1;
      end else if (linkPop && !linkPush) begin
        linkCnt_r <= linkCnt_r - 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dmaPar_r  <= 1'b0;
      linkPar_r <= 1'b0;
    end else begin
      if (lanePop) begin
        dmaPar_r <= laneHead.par;
      end
      if (linkPop) begin
        linkPar_r <= linkHead.par;
      end
    end
  end

  // output latch and holding register, the residual bytes outside the fifo
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latchFull_r <= 1'b0;
      holdFull_r  <= 1'b0;
      latch_r     <= RESET_BYTE;
      hold_r      <= RESET_BYTE;
    end else begin
      if (wrHit[OUT_LATCH_ADDR] && !diagCtrl_r[LINK_FIFO_WE_BIT]) begin
        latch_r     <= bus.wdata;
        latchFull_r <= 1'b1;
      end else if (latchTake && latchFull_r) begin
        latchFull_r <= 1'b0;
      end
      if (latchTake && latchFull_r && syncMode) begin
        hold_r     <= latch_r;
        holdFull_r <= 1'b1;
      end else if (holdSent) begin
        holdFull_r <= 1'b0;
      end
    end
  end

  // counter drops as bytes enter the fifo, pointer as they leave
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byteCnt_r <= RESET_BYTE;
      fifoPtr_r <= 6'h00;
    end else if (wrHit[BYTE_COUNT_ADDR]) begin
      byteCnt_r <= bus.wdata;
      fifoPtr_r <= bus.wdata[5:0];
    end else begin
      if (dmaIn && running_r && byteCnt_r != 8'h00) begin
        byteCnt_r <= byteCnt_r - 8'h01;
      end
      if (dmaOut && running_r) begin
        fifoPtr_r <= fifoPtr_r - 6'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swAbort_r <= 1'b0;
    end else if (wrHit[INT_STATUS_ADDR]) begin
      swAbort_r <= bus.wdata[SW_ABORT_BIT];
    end
  end

  // abort touches only the sequencer and its flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abortPend_r <= 1'b0;
      abortFlag_r <= 1'b0;
    end else begin
      if (abortFire) begin
        abortPend_r <= 1'b0;
      end else if (abortReq && !abortFlag_r) begin
        abortPend_r <= 1'b1;
      end
      if (abortFire) begin
        abortFlag_r <= 1'b1;
      end else if (statusRead) begin
        abortFlag_r <= 1'b0;
      end
    end
  end

  // a high pointer byte write starts the sequencer; abort, disconnect or a request while idle stops it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running_r <= 1'b0;
      start_r   <= 1'b0;
      ip_r      <= 16'h0000;
    end else begin
      start_r <= wrHit[IP_HI_ADDR];
      if (wrHit[IP_LO_ADDR]) begin
        ip_r[7:0] <= bus.wdata;
      end else if (wrHit[IP_HI_ADDR]) begin
        ip_r[15:8] <= bus.wdata;
      end else if (instrFetch && running_r) begin
        ip_r <= ip_r + IP_STEP;
      end
      if (wrHit[IP_HI_ADDR]) begin
        running_r <= 1'b1;
      end else if (abortFire || linkDisconnect || (abortReq && !running_r)) begin
        running_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_r <= RESET_BYTE;
    end else begin
      rdData_r <= RESET_BYTE;
      if (bus.rd) begin
        unique case (bus.addr)
          DIAG_CTRL_ADDR:     rdData_r <= diagCtrl_r;
          DMA_TEST_DATA_ADDR: rdData_r <= lanePop ? laneHead.data : RESET_BYTE;
          PARITY_WRITE_ADDR:  rdData_r <= parWrite_r;
          TEST_STATUS_ADDR:   rdData_r <= 8'({6'h00, linkPar_r, dmaPar_r} << DMA_PAR_BIT);
          LINK_READBACK_ADDR: rdData_r <= linkPop ? linkHead.data : RESET_BYTE;
          OUT_LATCH_ADDR:     rdData_r <= latch_r;
          LINK_CTRL0_ADDR:    rdData_r <= ctrl0_r;
          LINK_CTRL1_ADDR:    rdData_r <= ctrl1_r;
          DMA_STATUS_ADDR:    rdData_r <= 8'({7'h0, abortFlag_r} << ABORT_FLAG_BIT);
          INT_STATUS_ADDR:   rdData_r <= {swAbort_r, 3'h0, linkConnected, 3'h0};
          BYTE_COUNT_ADDR:    rdData_r <= byteCnt_r;
          IP_LO_ADDR:         rdData_r <= ip_r[7:0];
          IP_HI_ADDR:         rdData_r <= ip_r[15:8];
          LINK_STATUS1_ADDR: rdData_r <= {1'b0, holdFull_r, latchFull_r, 5'h00};
          DMA_PTR_ADDR:       rdData_r <= {2'h0, fifoPtr_r};
          default:            rdData_r <= RESET_BYTE;
        endcase
      end
    end
  end

  assign rdData      = rdData_r;
  assign running     = running_r;
  assign startFetch  = start_r;
  assign instrPtr    = ip_r;
  assign linkOutByte = holdFull_r ? hold_r : latch_r;

  sequence laneWriteS;
    laneOn && wrHit[DMA_TEST_DATA_ADDR] && laneCnt_r[laneSel] == 4'h0;
  endsequence

  lane_disable_a: assert property (@(posedge clk) disable iff (rst)
    !laneOn |-> !lanePush && !lanePop)
    else $error("lane access while disabled");
  lane_order_a: assert property (@(posedge clk) disable iff (rst)
    laneWriteS ##1 (laneOn && rdHit[DMA_TEST_DATA_ADDR] && $stable(laneSel))
      |=> rdData == $past(bus.wdata, 2))
    else $error("lane readback out of order");
  dma_parity_a: assert property (@(posedge clk) disable iff (rst)
    lanePop |=> dmaPar_r == $past(laneHead.par))
    else $error("dma parity not latched");
  link_parity_a: assert property (@(posedge clk) disable iff (rst)
    linkPop |=> linkPar_r == $past(linkHead.par))
    else $error("link parity not latched");
  abort_clear_a: assert property (@(posedge clk) disable iff (rst)
    statusRead && !abortFire |=> !abortFlag_r)
    else $error("abort flag survived status read");
  abort_burst_a: assert property (@(posedge clk) disable iff (rst)
    $rose(abortFlag_r) |-> $past(!burstActive))
    else $error("abort during burst");
  abort_stop_a: assert property (@(posedge clk) disable iff (rst)
    abortFire |=> !running_r && $stable(byteCnt_r))
    else $error("abort did not stop cleanly");
  ip_start_a: assert property (@(posedge clk) disable iff (rst)
    wrHit[IP_HI_ADDR] |=> startFetch && running_r ##1 !startFetch)
    else $error("pointer write did not start");
  ip_step_a: assert property (@(posedge clk) disable iff (rst)
    instrFetch && running_r && !wrHit[IP_LO_ADDR] && !wrHit[IP_HI_ADDR]
      |=> instrPtr == $past(instrPtr) + IP_STEP)
    else $error("pointer not advanced by 8");
  fifo_clear_a: assert property (@(posedge clk) disable iff (rst)
    fifoClear |=> linkCnt_r == 4'h0 && laneCnt_r[0] == 4'h0)
    else $error("fifo clear failed");
endmodule
`default_nettype wire

// ### fda_host_model.sv
// host bus master model driving the register port and parity pins
`timescale 1ns/1ns
`default_nettype none
module fda_host_model
  import fda_pkg::*;
(
  input  wire logic         clk,
  input  wire logic [7:0]   rdData,
  output var  fda_pkg::fda_bus_s bus,
  output logic [3:0]        hostParity,
  output logic              abortPinN
);
  initial begin
    bus = '0;
    hostParity = 4'h0;
    abortPinN = 1'b1;
  end

  // byte lane 0 only, so its parity goes out on pin 0
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic p = 1'b0);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    hostParity <= {3'h0, p};
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdData;
  endtask

  // write then read with no idle cycle between the strobes
  task automatic wrRd(input logic [3:0] wa, input logic [7:0] d, input logic [3:0] ra,
                      output logic [7:0] q);
    @(posedge clk);
    bus <= '{addr: wa, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ra, wdata: ~d, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 q = rdData;
  endtask

  // caller clears parity generation first, the pin is shared
  task automatic pinAbort();
    @(posedge clk);
    abortPinN <= 1'b0;
    @(posedge clk);
    abortPinN <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### fifo_diag_and_abort_recovery_tb.sv
// self-checking bench for the fifo diagnostic and abort recovery block
`timescale 1ns/1ns
`default_nettype none
module fifo_diag_and_abort_recovery_tb;
  import fda_pkg::*;
  logic        clk, rst, abortPinN, running, startFetch;
  logic        burstActive, receiveMode, syncMode, linkConnected;
  logic        dmaIn, dmaOut, instrFetch, latchTake, holdSent, linkDisconnect;
  logic [3:0]  hostParity;
  logic [7:0]  rdData, linkOutByte, v;
  logic [8:0]  e;
  logic [15:0] instrPtr;
  logic [31:0] seed;
  logic [8:0]  q[LANES][$];
  logic [8:0]  lq[$];
  fda_bus_s    bus;
  int          failures, n_checks, cyc, starts, cnt, ptr;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  fda_diag_abort DUT (.clk(clk), .rst(rst), .bus(bus), .rdData(rdData),
    .hostParity(hostParity), .abortPinN(abortPinN), .burstActive(burstActive),
    .receiveMode(receiveMode), .dmaIn(dmaIn), .dmaOut(dmaOut), .instrFetch(instrFetch),
    .linkConnected(linkConnected), .linkDisconnect(linkDisconnect), .syncMode(syncMode),
    .latchTake(latchTake), .holdSent(holdSent), .running(running),
    .startFetch(startFetch), .instrPtr(instrPtr), .linkOutByte(linkOutByte));

  fda_host_model host (.clk(clk), .rdData(rdData), .bus(bus),
    .hostParity(hostParity), .abortPinN(abortPinN));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    starts <= starts + int'(startFetch === 1'b1);
    if (cyc == 6000) begin
      failures++;
      wrap_up();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic rdk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x,
                     input string n);
    host.rd(a, v);
    chk(n, x, v & m);
  endtask

  // order: dmaIn dmaOut instrFetch latchTake holdSent linkDisconnect
  task automatic tick(input logic [5:0] w);
    @(posedge clk);
    {dmaIn, dmaOut, instrFetch, latchTake, holdSent, linkDisconnect} <= w;
    @(posedge clk);
    {dmaIn, dmaOut, instrFetch, latchTake, holdSent, linkDisconnect} <= 6'h00;
  endtask

  task automatic start(input logic [7:0] hi, input logic [7:0] lo);
    host.wr(IP_LO_ADDR, lo);
    host.wr(IP_HI_ADDR, hi);
    repeat (2) @(posedge clk);
    chk("running", 16'h1, {15'h0, running});
  endtask

  // stop is bounded, a stuck sequencer must not hang the run
  task automatic waitStop();
    for (int i = 0; i < 20 && running !== 1'b0; i++) @(posedge clk);
    chk("stopped", 16'h0, {15'h0, running});
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {burstActive, receiveMode, syncMode, linkConnected} = 4'h0;
    {dmaIn, dmaOut, instrFetch, latchTake, holdSent, linkDisconnect} = 6'h00;
    {cyc, starts, failures, n_checks} = '0;
    seed = 32'd6;
    e = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) rdk(4'(a), 8'hFF, 8'h00, "reset");
    $display("test reset done");

    host.wr(DMA_TEST_DATA_ADDR, 8'h5A);
    for (int l = 0; l < LANES; l++) begin
      host.wr(DIAG_CTRL_ADDR, 8'(4 + l));
      for (int i = 0; i <= DEPTH; i++) begin
        v = rnd();
        host.wr(PARITY_WRITE_ADDR, {4'h0, seed[9], 3'h0});
        host.wr(DMA_TEST_DATA_ADDR, v);
        if (i < DEPTH) q[l].push_back({seed[9], v});
      end
    end
    for (int l = 0; l < LANES; l++) begin
      host.wr(DIAG_CTRL_ADDR, 8'(4 + l));
      for (int i = 0; i <= DEPTH; i++) begin
        e = (q[l].size() > 0) ? q[l].pop_front() : {e[8], 8'h00};
        rdk(DMA_TEST_DATA_ADDR, 8'hFF, e[7:0], "lane data");
        rdk(TEST_STATUS_ADDR, 8'h08, {4'h0, e[8], 3'h0}, "lane par");
      end
    end
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    $display("test lanes done");

    for (int m = 0; m < 3; m++) begin
      host.wr(LINK_CTRL0_ADDR, (m > 0) ? 8'h04 : 8'h00);
      host.wr(LINK_CTRL1_ADDR, (m == 2) ? 8'h04 : 8'h00);
      host.wr(DIAG_CTRL_ADDR, 8'h08);
      for (int i = 0; i < DEPTH; i++) begin
        v = rnd();
        host.wr(OUT_LATCH_ADDR, v, seed[9]);
        lq.push_back({(m == 0) ? seed[9] : (m == 1) ? ~^v : ^v, v});
      end
      for (int i = 0; i < DEPTH; i++) begin
        e = lq.pop_front();
        rdk(LINK_READBACK_ADDR, 8'hFF, e[7:0], "link data");
        rdk(TEST_STATUS_ADDR, 8'h10, {3'h0, e[8], 4'h0}, "link par");
      end
    end
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    $display("test link fifo done");

    host.wr(OUT_LATCH_ADDR, 8'hA5);
    rdk(LINK_STATUS1_ADDR, 8'h60, 8'h20, "latch full");
    @(posedge clk) syncMode <= 1'b1;
    tick(6'b000100);
    host.wr(OUT_LATCH_ADDR, 8'h3C);
    rdk(LINK_STATUS1_ADDR, 8'h60, 8'h60, "both full");
    chk("out byte", 16'h00A5, {8'h00, linkOutByte});
    tick(6'b000010);
    rdk(LINK_STATUS1_ADDR, 8'h60, 8'h20, "hold sent");
    host.wr(DIAG_CTRL_ADDR, 8'h08);
    host.wr(OUT_LATCH_ADDR, 8'h77);
    host.wr(DIAG_CTRL_ADDR, 8'h04);
    host.wr(DMA_TEST_DATA_ADDR, 8'h55);
    host.wr(DMA_PTR_ADDR, 8'h40);
    rdk(DMA_TEST_DATA_ADDR, 8'hFF, 8'h00, "lane cleared");
    rdk(LINK_READBACK_ADDR, 8'hFF, 8'h00, "link cleared");
    host.wrRd(DMA_TEST_DATA_ADDR, 8'hC3, DMA_TEST_DATA_ADDR, v);
    chk("lane b2b", 16'h00C3, {8'h00, v});
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    $display("test latch and clear done");

    host.wr(BYTE_COUNT_ADDR, 8'h10);
    cnt = 16;
    ptr = 16;
    start(8'h12, 8'h40);
    repeat (3) tick(6'b001000);
    repeat (5) tick(6'b100000);
    repeat (2) tick(6'b010000);
    cnt -= 5;
    ptr -= 2;
    rdk(BYTE_COUNT_ADDR, 8'hFF, 8'(cnt), "count");
    rdk(DMA_PTR_ADDR, 8'h3F, 8'(ptr), "pointer");
    chk("residual", 16'h3, {8'h00, (v - 8'(cnt)) & 8'h3F});
    @(posedge clk) burstActive <= 1'b1;
    host.wr(INT_STATUS_ADDR, 8'h80);
    repeat (4) @(posedge clk);
    chk("burst hold", 16'h1, {15'h0, running});
    linkConnected <= 1'b1;
    burstActive <= 1'b0;
    waitStop();
    chk("ip kept", 16'h1258, instrPtr);
    rdk(INT_STATUS_ADDR, 8'h08, 8'h08, "connected");
    rdk(DMA_STATUS_ADDR, 8'h10, 8'h10, "abort flag");
    repeat (2) @(posedge clk);
    rdk(DMA_STATUS_ADDR, 8'h10, 8'h10, "re-raise");
    host.wr(INT_STATUS_ADDR, 8'h00);
    host.rd(DMA_STATUS_ADDR, v);
    rdk(DMA_STATUS_ADDR, 8'h10, 8'h00, "abort clear");
    $display("test abort done");

    start(8'h20, 8'h00);
    tick(6'b001000);
    tick(6'b000001);
    waitStop();
    chk("ip disc", 16'h2008, instrPtr);
    rdk(BYTE_COUNT_ADDR, 8'hFF, 8'(cnt), "count disc");
    host.wr(LINK_CTRL0_ADDR, 8'h00);
    host.wr(DIAG_CTRL_ADDR, 8'h04);
    host.wr(DMA_TEST_DATA_ADDR, 8'h99);
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    receiveMode <= 1'b1;
    start(8'h30, 8'h00);
    host.pinAbort();
    repeat (4) @(posedge clk);
    chk("flush hold", 16'h1, {15'h0, running});
    repeat (3) tick(6'b010000);
    waitStop();
    rdk(DMA_STATUS_ADDR, 8'h10, 8'h10, "pin abort");
    chk("starts", 16'h3, 16'(starts));
    $display("test restart done");
    wrap_up();
  end
endmodule
`default_nettype wire
